// ---- logic/secp_top.sv ----
// What this block does
// - word width strap picks 16 or 8 bits
// - serial input sampled on serial clock rise
// - output released except read or status
// - status low while busy, high when ready
// - deselect releases the serial output at once
// - sub-code 11 under opcode 00 enables programming
// - sub-code 10 erases all, then status
// - sub-code 01 writes all with one word
// - sub-code 00 disables programming, output released
// - address field width follows strap; usable address bits follow variant
// - programming lasts 5, 15 or 30 ms
// - start bit: first rise with select and input high
// - read puts one zero before the word
// - starts disabled; reads allowed, enabled or not, except while busy
// - deselect resets decoder, programming runs on
`timescale 1ns/1ps
`include "secp_cfg.svh"
module secp_top #(
    parameter int WORD_PROG_CYCLES = `SECP_WORD_PROG_CYCLES,
    parameter int BULK_ERASE_CYCLES = `SECP_BULK_ERASE_CYCLES,
    parameter int BULK_WRITE_CYCLES = `SECP_BULK_WRITE_CYCLES,
    parameter int TIMER_WIDTH = 21
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RSTN,
    // serial link pins
    input wire logic SEL,
    input wire logic SCLK,
    input wire logic SERIAL_IN,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE,
    // word width strap
    input wire logic WORD_WIDTH_SELECT,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // memory array side
    output secp_pkg::secp_rd_req_t MEM_RD,
    input wire logic [15:0] MEM_RD_DATA,
    output secp_pkg::secp_prog_req_t MEM_PROG,
    output logic PROG_BUSY
);

    secp_pkg::secp_core_t s; // registered state
    secp_pkg::secp_core_t n; // next state

    logic rise; // serial clock rising edge while selected
    logic busy; // self-timed cycle running
    logic [4:0] alen; // address field length
    logic [4:0] dlen; // data word length
    logic [10:0] addr_mask; // usable address bits
    logic [10:0] a_new; // address field with the current bit
    logic [15:0] d_new; // data field with the current bit
    logic [1:0] sub_new; // special sub-code from the new address
    logic go_prog; // a programming instruction is complete
    secp_pkg::secp_prog_op_t go_op; // which programming cycle
    logic [15:0] go_wdata; // word to program
    logic prog_start; // timer load
    logic [TIMER_WIDTH-1:0] prog_cycles; // timer load value

    // field geometry from strap and variant
    always_comb
    begin
        if (WORD_WIDTH_SELECT)
        begin
            alen = `SECP_ADDR_LEN_X16;
            dlen = `SECP_DATA_LEN_X16;
            addr_mask = s.ctrl_large ? `SECP_ADDR_MASK_X16_LARGE : `SECP_ADDR_MASK_X16_SMALL;
            sub_new = a_new[9:8];
        end
        else
        begin
            alen = `SECP_ADDR_LEN_X8;
            dlen = `SECP_DATA_LEN_X8;
            addr_mask = s.ctrl_large ? `SECP_ADDR_MASK_X8_LARGE : `SECP_ADDR_MASK_X8_SMALL;
            sub_new = a_new[10:9];
        end
    end

    // edge detect and shift-in values
    assign rise = SEL & SCLK & ~s.sclk_prev;
    assign a_new = {s.addr[9:0], SERIAL_IN};
    assign d_new = {s.data[14:0], SERIAL_IN};

    // next-state logic of the command port
    always_comb
    begin
        n = s;
        go_prog = 1'b0;
        go_op = secp_pkg::SECP_PROG_ERASE;
        go_wdata = 16'hffff;
        prog_start = 1'b0;
        prog_cycles = '0;
        n.sclk_prev = SCLK;
        n.rd_req.stb = 1'b0;
        n.prog_req.stb = 1'b0;
        n.rdata = 32'h00000000;
        // register writes
        if (REG_WR && REG_ADDR == `SECP_REG_CTRL)
        begin
            n.ctrl_large = REG_WDATA[`SECP_CTRL_LARGE_BIT];
        end
        // register reads, answered next cycle
        if (REG_RD)
        begin
            case (REG_ADDR)
                `SECP_REG_CTRL:
                begin
                    n.rdata = {31'h00000000, s.ctrl_large};
                end
                `SECP_REG_STATUS:
                begin
                    n.rdata = {28'h0000000, SEL, WORD_WIDTH_SELECT, s.prog_en, busy};
                end
                default:
                begin
                    n.rdata = 32'h00000000;
                end
            endcase
        end
        if (!SEL)
        begin
            // deselected: decoder held in reset, timer runs on
            n.state = secp_pkg::SECP_IDLE;
            n.oe = 1'b0;
            n.cnt = 5'h00;
            n.opcode = 2'h0;
        end
        else
        begin
            case (s.state)
                secp_pkg::SECP_IDLE:
                begin
                    if (busy)
                    begin
                        // reselected during a cycle: show status
                        n.state = secp_pkg::SECP_STATUS;
                        n.oe = 1'b1;
                        n.so = 1'b0;
                    end
                    else if (rise && SERIAL_IN)
                    begin
                        n.state = secp_pkg::SECP_OPCODE;
                        n.cnt = `SECP_OPCODE_LEN;
                    end
                end
                secp_pkg::SECP_OPCODE:
                begin
                    if (rise)
                    begin
                        n.opcode = {s.opcode[0], SERIAL_IN};
                        n.cnt = s.cnt - 5'h01;
                        if (s.cnt == 5'h01)
                        begin
                            n.state = secp_pkg::SECP_ADDR;
                            n.cnt = alen;
                        end
                    end
                end
                secp_pkg::SECP_ADDR:
                begin
                    if (rise)
                    begin
                        n.addr = a_new;
                        n.cnt = s.cnt - 5'h01;
                        if (s.cnt == 5'h01)
                        begin
                            // last address bit: decode
                            n.state = secp_pkg::SECP_IDLE;
                            case (s.opcode)
                                `SECP_OP_READ:
                                begin
                                    n.addr = a_new & addr_mask;
                                    n.rd_req.stb = 1'b1;
                                    n.rd_req.addr = a_new & addr_mask;
                                    n.so = 1'b0;
                                    n.oe = 1'b1;
                                    n.cnt = 5'h01;
                                    n.state = secp_pkg::SECP_RD_LOAD;
                                end
                                `SECP_OP_WRITE:
                                begin
                                    n.addr = a_new & addr_mask;
                                    n.cnt = dlen;
                                    n.state = secp_pkg::SECP_DATA;
                                end
                                `SECP_OP_ERASE:
                                begin
                                    n.addr = a_new & addr_mask;
                                    go_prog = 1'b1;
                                    go_op = secp_pkg::SECP_PROG_ERASE;
                                end
                                default:
                                begin
                                    case (sub_new)
                                        `SECP_SUB_ENABLE:
                                        begin
                                            n.prog_en = 1'b1;
                                        end
                                        `SECP_SUB_DISABLE:
                                        begin
                                            n.prog_en = 1'b0;
                                        end
                                        `SECP_SUB_ERASE_ALL:
                                        begin
                                            go_prog = 1'b1;
                                            go_op = secp_pkg::SECP_PROG_ERASE_ALL;
                                        end
                                        default:
                                        begin
                                            n.cnt = dlen;
                                            n.state = secp_pkg::SECP_DATA;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                secp_pkg::SECP_DATA:
                begin
                    if (rise)
                    begin
                        n.data = d_new;
                        n.cnt = s.cnt - 5'h01;
                        if (s.cnt == 5'h01)
                        begin
                            // last data bit: word or whole-array write
                            go_prog = 1'b1;
                            go_op = (s.opcode == `SECP_OP_WRITE) ?
                                secp_pkg::SECP_PROG_WRITE : secp_pkg::SECP_PROG_WRITE_ALL;
                            go_wdata = WORD_WIDTH_SELECT ? d_new : {8'h00, d_new[7:0]};
                        end
                    end
                end
                secp_pkg::SECP_RD_LOAD:
                begin
                    // array answers one cycle after the request
                    if (s.cnt != 5'h00)
                    begin
                        n.cnt = 5'h00;
                    end
                    else
                    begin
                        n.data = WORD_WIDTH_SELECT ? MEM_RD_DATA : {MEM_RD_DATA[7:0], 8'h00};
                        n.cnt = dlen;
                        n.state = secp_pkg::SECP_RD_SHIFT;
                    end
                end
                secp_pkg::SECP_RD_SHIFT:
                begin
                    if (rise)
                    begin
                        // msb first; the word is left aligned
                        n.so = s.data[15];
                        n.data = {s.data[14:0], 1'b0};
                        n.cnt = s.cnt - 5'h01;
                        if (s.cnt == 5'h01)
                        begin
                            // sequential read of the next word
                            n.addr = (s.addr + 11'h001) & addr_mask;
                            n.rd_req.stb = 1'b1;
                            n.rd_req.addr = (s.addr + 11'h001) & addr_mask;
                            n.cnt = 5'h01;
                            n.state = secp_pkg::SECP_RD_LOAD;
                        end
                    end
                end
                secp_pkg::SECP_STATUS:
                begin
                    n.so = ~busy;
                    if (rise && SERIAL_IN && !busy)
                    begin
                        // next start bit ends the status display
                        n.state = secp_pkg::SECP_OPCODE;
                        n.cnt = `SECP_OPCODE_LEN;
                        n.oe = 1'b0;
                    end
                end
                default:
                begin
                    n.state = secp_pkg::SECP_IDLE;
                    n.oe = 1'b0;
                end
            endcase
            // launch a programming cycle only when enabled
            if (go_prog)
            begin
                if (s.prog_en)
                begin
                    n.prog_req.stb = 1'b1;
                    n.prog_req.op = go_op;
                    n.prog_req.addr = n.addr;
                    n.prog_req.wdata = go_wdata;
                    n.state = secp_pkg::SECP_STATUS;
                    n.oe = 1'b1;
                    n.so = 1'b0;
                    prog_start = 1'b1;
                    case (go_op)
                        secp_pkg::SECP_PROG_ERASE_ALL:
                        begin
                            prog_cycles = TIMER_WIDTH'(BULK_ERASE_CYCLES);
                        end
                        secp_pkg::SECP_PROG_WRITE_ALL:
                        begin
                            prog_cycles = TIMER_WIDTH'(BULK_WRITE_CYCLES);
                        end
                        default:
                        begin
                            prog_cycles = TIMER_WIDTH'(WORD_PROG_CYCLES);
                        end
                    endcase
                end
                else
                begin
                    n.state = secp_pkg::SECP_IDLE;
                end
            end
        end
    end

    // state register
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s <= '0;
            s.ctrl_large <= `SECP_CTRL_LARGE_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    // programming cycle timer
    secp_prog_timer #(
        .WIDTH(TIMER_WIDTH)
    ) u_timer (
        .clk(REF_CLK),
        .rstn(RSTN),
        .load(prog_start),
        .load_val(prog_cycles),
        .busy(busy)
    );

    // outputs
    assign SERIAL_OUT = s.so;
    assign SERIAL_OUT_OE = s.oe & SEL;
    assign REG_RDATA = s.rdata;
    assign MEM_RD = s.rd_req;
    assign MEM_PROG = s.prog_req;
    assign PROG_BUSY = busy;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    // last address edge of a read
    sequence read_addr_done_s;
        s.state == secp_pkg::SECP_ADDR && rise && s.cnt == 5'h01 && s.opcode == `SECP_OP_READ;
    endsequence

    // dummy zero in the same cycle as the array request
    sequence dummy_zero_s;
        SERIAL_OUT_OE && !SERIAL_OUT && MEM_RD.stb;
    endsequence

    // last address edge of an enabled erase
    sequence erase_done_s;
        s.state == secp_pkg::SECP_ADDR && rise && s.cnt == 5'h01 &&
            s.opcode == `SECP_OP_ERASE && s.prog_en;
    endsequence

    oe_only_active_a: assert property (SERIAL_OUT_OE |-> s.state inside
        {secp_pkg::SECP_RD_LOAD, secp_pkg::SECP_RD_SHIFT, secp_pkg::SECP_STATUS})
        else $error("serial output driven outside read or status");

    release_desel_a: assert property (!SEL |-> !SERIAL_OUT_OE)
        else $error("serial output driven while deselected");

    status_level_a: assert property (s.state == secp_pkg::SECP_STATUS &&
        $past(s.state) == secp_pkg::SECP_STATUS |-> SERIAL_OUT == !$past(busy))
        else $error("status level does not follow busy");

    read_dummy_a: assert property (read_addr_done_s |=> dummy_zero_s ##1
        s.state == secp_pkg::SECP_RD_LOAD)
        else $error("read did not start with a zero bit");

    erase_launch_a: assert property (erase_done_s |=> MEM_PROG.stb &&
        MEM_PROG.op == secp_pkg::SECP_PROG_ERASE && busy && !SERIAL_OUT)
        else $error("erase did not launch a busy cycle");

    enable_gate_a: assert property (MEM_PROG.stb |-> $past(s.prog_en))
        else $error("programming launched while disabled");

    start_bit_a: assert property (s.state == secp_pkg::SECP_IDLE && SEL && !busy &&
        !(rise && SERIAL_IN) |=> s.state != secp_pkg::SECP_OPCODE)
        else $error("start recognised without start bit");

    desel_reset_a: assert property (!SEL |=> s.state == secp_pkg::SECP_IDLE)
        else $error("decoder not reset on deselect");

    bulk_time_a: assert property (prog_start && go_op == secp_pkg::SECP_PROG_WRITE_ALL
        |-> prog_cycles == TIMER_WIDTH'(BULK_WRITE_CYCLES))
        else $error("write-all cycle time wrong");

    width_load_a: assert property (s.state == secp_pkg::SECP_RD_LOAD && s.cnt == 5'h00 && SEL
        |=> s.cnt == (WORD_WIDTH_SELECT ? `SECP_DATA_LEN_X16 : `SECP_DATA_LEN_X8))
        else $error("read word length does not follow strap");

endmodule

// ---- logic/secp_cfg.svh ----
`ifndef SECP_CFG_SVH
`define SECP_CFG_SVH

// reference clock rate in hertz
`define SECP_REF_CLK_HZ 40000000

// worst-case self-timed programming times in milliseconds
`define SECP_WORD_PROG_TIME_MS 5
`define SECP_BULK_ERASE_TIME_MS 15
`define SECP_BULK_WRITE_TIME_MS 30

// least deselect gap the master keeps, in nanoseconds
`define SECP_DESELECT_GAP_TIME_NS 250

// programming times as clock counts, rounded down
`define SECP_WORD_PROG_CYCLES ((`SECP_WORD_PROG_TIME_MS * `SECP_REF_CLK_HZ) / 1000)
`define SECP_BULK_ERASE_CYCLES ((`SECP_BULK_ERASE_TIME_MS * `SECP_REF_CLK_HZ) / 1000)
`define SECP_BULK_WRITE_CYCLES ((`SECP_BULK_WRITE_TIME_MS * `SECP_REF_CLK_HZ) / 1000)

// two-bit opcodes following the start marker bit
`define SECP_OP_SPECIAL 2'h0
`define SECP_OP_WRITE 2'h1
`define SECP_OP_READ 2'h2
`define SECP_OP_ERASE 2'h3

// sub-codes in the top two address bits of the special opcode
`define SECP_SUB_DISABLE 2'h0
`define SECP_SUB_WRITE_ALL 2'h1
`define SECP_SUB_ERASE_ALL 2'h2
`define SECP_SUB_ENABLE 2'h3

// field lengths in serial clocks
`define SECP_OPCODE_LEN 5'h02
`define SECP_ADDR_LEN_X16 5'h0a
`define SECP_ADDR_LEN_X8 5'h0b
`define SECP_DATA_LEN_X16 5'h10
`define SECP_DATA_LEN_X8 5'h08

// usable address bits per variant and word width
`define SECP_ADDR_MASK_X16_LARGE 11'h3ff
`define SECP_ADDR_MASK_X16_SMALL 11'h1ff
`define SECP_ADDR_MASK_X8_LARGE 11'h7ff
`define SECP_ADDR_MASK_X8_SMALL 11'h3ff

// register port map
`define SECP_REG_CTRL 4'h0
`define SECP_REG_STATUS 4'h4
`define SECP_CTRL_LARGE_BIT 0
`define SECP_CTRL_LARGE_RESET 1'h1

`endif

// ---- logic/secp_pkg.sv ----
package secp_pkg;

    // command sequencer states
    typedef enum logic [2:0] {
        SECP_IDLE,
        SECP_OPCODE,
        SECP_ADDR,
        SECP_DATA,
        SECP_RD_LOAD,
        SECP_RD_SHIFT,
        SECP_STATUS
    } secp_state_t;

    // kind of self-timed programming cycle
    typedef enum logic [1:0] {
        SECP_PROG_ERASE,
        SECP_PROG_WRITE,
        SECP_PROG_ERASE_ALL,
        SECP_PROG_WRITE_ALL
    } secp_prog_op_t;

    // array read request
    typedef struct packed {
        logic stb;
        logic [10:0] addr;
    } secp_rd_req_t;

    // array programming request
    typedef struct packed {
        logic stb;
        secp_prog_op_t op;
        logic [10:0] addr;
        logic [15:0] wdata;
    } secp_prog_req_t;

    // whole state of the command port
    typedef struct packed {
        secp_state_t state;
        logic sclk_prev;
        logic [4:0] cnt;
        logic [1:0] opcode;
        logic [10:0] addr;
        logic [15:0] data;
        logic so;
        logic oe;
        logic prog_en;
        logic ctrl_large;
        logic [31:0] rdata;
        secp_rd_req_t rd_req;
        secp_prog_req_t prog_req;
    } secp_core_t;

endpackage

// ---- logic/secp_prog_timer.sv ----
`timescale 1ns/1ps
// down counter timing one self-timed programming cycle
module secp_prog_timer #(
    parameter int WIDTH = 21
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // load request and cycle count
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    // high while the cycle runs
    output logic busy
);

    // timer state
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } secp_timer_t;

    secp_timer_t s; // registered state
    secp_timer_t n; // next state

    // load wins, otherwise count down to zero
    always_comb
    begin
        n = s;
        if (load)
        begin
            n.count = load_val;
        end
        else if (s.count != '0)
        begin
            n.count = s.count - WIDTH'(1);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign busy = (s.count != '0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // a load above one holds busy for the next two cycles
    load_busy_a: assert property (load && load_val > WIDTH'(1) |=> busy ##1 busy)
        else $error("programming timer dropped busy early");

endmodule

// ---- verification/secp_host_model.sv ----
`timescale 1ns/1ps
// serial master: clock stands low between frames, data idles inverted
module secp_host_model (
    // clock
    input wire logic clk,
    // link pins
    output logic sel,
    output logic sclk,
    output logic sdi
);
    // idle pins at time zero
    initial
    begin
        sel = 1'b0;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // one bit: data set with clock low, clock rises two cycles later
    task automatic bit_out(input logic b);
        @(posedge clk);
        sel <= 1'b1;
        sclk <= 1'b0;
        sdi <= b;
        repeat (2) @(posedge clk);
        sclk <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // n bits, msb first
    task automatic send(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_out(v[i]);
        end
    endtask
    // deselect and keep the gap before the next instruction
    task automatic gap();
        @(posedge clk);
        sel <= 1'b0;
        sclk <= 1'b0;
        sdi <= ~sdi;
        repeat (10) @(posedge clk);
    endtask
    // reselect without clocking, to poll status
    task automatic sel_on();
        @(posedge clk);
        sel <= 1'b1;
    endtask
endmodule

// ---- verification/secp_tb_top.sv ----
`timescale 1ns/1ps
module secp_tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic wws = 1'b1; // 16-bit words
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic sel, sclk, sdi, so, so_oe, busy;
    secp_pkg::secp_rd_req_t mem_rd;
    logic [15:0] mem_rd_data = 16'h0;
    secp_pkg::secp_prog_req_t mem_prog, last_prog;
    int n_prog = 0;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] word;

    secp_top #(.WORD_PROG_CYCLES(50), .BULK_ERASE_CYCLES(100), .BULK_WRITE_CYCLES(150)) u_dut (
        .REF_CLK(ref_clk), .RSTN(rstn), .SEL(sel), .SCLK(sclk), .SERIAL_IN(sdi),
        .SERIAL_OUT(so), .SERIAL_OUT_OE(so_oe), .WORD_WIDTH_SELECT(wws),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .MEM_RD(mem_rd), .MEM_RD_DATA(mem_rd_data),
        .MEM_PROG(mem_prog), .PROG_BUSY(busy));
    secp_host_model h (.clk(ref_clk), .sel(sel), .sclk(sclk), .sdi(sdi));

    initial forever #12.5 ref_clk = ~ref_clk;

    // array answers one cycle after a read request, garbage otherwise; timeout
    always @(posedge ref_clk)
    begin
        mem_rd_data <= mem_rd.stb ? ({5'h00, mem_rd.addr} ^ 16'ha5c3) : ~mem_rd_data;
        if (mem_prog.stb)
        begin
            n_prog <= n_prog + 1;
            last_prog <= mem_prog;
        end
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // register read, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
    endtask
    // register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // programming instruction; en says whether it must start a cycle
    task automatic prog(input logic [1:0] opc, input logic [9:0] a, input logic wd,
                        input logic en, input logic [1:0] eop);
        int n0;
        n0 = n_prog;
        h.send({13'h0, 1'b1, opc}, 3);
        h.send({6'h0, a}, 10);
        if (wd)
            h.send(16'hc35a, 16);
        @(negedge ref_clk);
        chk(32'(n_prog - n0), 32'(en));
        if (en)
        begin
            chk(32'(last_prog.op), 32'(eop));
            if (wd)
                chk(32'(last_prog.wdata), 32'hc35a);
            if (opc != 2'h0)
                chk(32'(last_prog.addr), 32'(a));
            chk(32'({so_oe, so, busy}), 32'h5);
            h.gap();
            chk(32'({so_oe, busy}), 32'h1);
            h.sel_on();
            repeat (3) @(negedge ref_clk);
            chk(32'({so_oe, so}), 32'h2);
            for (int i = 0; i < 400 && busy; i++)
                @(negedge ref_clk);
            @(negedge ref_clk);
            chk(32'({so_oe, so, busy}), 32'h6);
        end
        else
            chk(32'(so_oe), 32'h0);
        h.gap();
    endtask
    // read one word of w bits: dummy zero, then the word msb first
    task automatic rd_word(input logic [10:0] a, input int w);
        h.send(16'h0006, 3);
        h.send({5'h0, a}, (w == 16) ? 10 : 11);
        @(negedge ref_clk);
        chk(32'({so_oe, so}), 32'h2);
        word = 16'h0000;
        for (int i = w - 1; i >= 0; i--)
        begin
            h.bit_out(1'b0);
            @(negedge ref_clk);
            word[i] = so;
        end
        chk(32'(word), 32'(({5'h0, a} ^ 16'ha5c3) & ((w == 16) ? 16'hffff : 16'h00ff)));
        h.gap();
        chk(32'(so_oe), 32'h0);
    endtask
    // verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        chk(32'({so_oe, busy}), 32'h0);
        rd(4'h4, 32'h4);
        rd(4'h8, 32'h0);
        rd(4'h0, 32'h1);
        $display("registers done");
        prog(2'h3, 10'h155, 1'b0, 1'b0, 2'h0);
        prog(2'h0, 10'h300, 1'b0, 1'b0, 2'h0);
        rd(4'h4, 32'h6);
        prog(2'h3, 10'h2aa, 1'b0, 1'b1, 2'h0);
        prog(2'h1, 10'h0f0, 1'b1, 1'b1, 2'h1);
        prog(2'h0, 10'h200, 1'b0, 1'b1, 2'h2);
        prog(2'h0, 10'h100, 1'b1, 1'b1, 2'h3);
        $display("programming done");
        rd_word(11'h3ff, 16);
        rd_word(11'h001, 16);
        wws <= 1'b0;
        rd_word(11'h5a5, 8);
        wws <= 1'b1;
        $display("reads done");
        prog(2'h0, 10'h000, 1'b0, 1'b0, 2'h0);
        prog(2'h1, 10'h011, 1'b1, 1'b0, 2'h0);
        wr(4'h0, 32'h0);
        rd(4'h0, 32'h0);
        $display("disable done");
        summarize();
    end
endmodule
